//--- hw/stce_pkg.sv
// Shared constants and types for the string/timer command executer
package stce_pkg;
  localparam logic [7:0] OP_SEL_ADVANCE = 8'hEE;
  localparam logic [7:0] OP_TEXT_INSERT = 8'hE5;
  localparam logic [7:0] OP_SEL_DEFINE  = 8'hE4;
  localparam logic [7:0] OP_TEXT_LOAD   = 8'hE3;
  localparam logic [7:0] OP_TO_REAL     = 8'hEA;
  localparam logic [7:0] OP_TO_INTEGER  = 8'hEB;
  localparam logic [7:0] OP_SWAP        = 8'h12;
  localparam logic [7:0] OP_SWAP_ACC    = 8'h13;
  localparam logic [7:0] OP_SYNC        = 8'hF0;
  localparam logic [7:0] OP_TABLE       = 8'h85;
  localparam logic [7:0] OP_TANGENT     = 8'h49;
  localparam logic [7:0] OP_FINE_TICK   = 8'hD9;
  localparam logic [7:0] OP_READ_SEC    = 8'hD8;
  localparam logic [7:0] OP_LOAD_SEC    = 8'hD7;
  localparam logic [7:0] OP_LOG_STOP    = 8'hF8;
  localparam logic [7:0] SYNC_REPLY     = 8'h5C;
  localparam logic [7:0] LOG_STOP_CHAR  = 8'h21;
  localparam logic [6:0] TEXT_MAX       = 7'h7F;
  localparam logic [7:0] REG_WIDE_BASE  = 8'h80;
  localparam logic [7:0] REG_ZERO       = 8'h00;
  localparam int         CLK_MHZ        = 100;
  localparam int         US_NS          = 1000;
  localparam int         CYC_PER_US     = US_NS * CLK_MHZ / 1000;
  localparam logic [9:0] US_PER_MS      = 10'h03E8;
  localparam logic [9:0] MS_PER_S       = 10'h03E8;
  typedef enum {ST_OPCODE, ST_ARG1, ST_ARG2, ST_STRING, ST_TBL_SIZE, ST_TBL_DATA, ST_EXEC,
                ST_REG_RD, ST_REG_WR} stce_state_t;
endpackage

//--- hw/stce_exec.sv
// String, swap, table, timer and trace command executer
`timescale 1ns/1ps
// Behaviour
// - Advance point one, length zero, clamp end
// - Insert string at point, point after it (code overwrites in place, tail not shifted)
// - Strings truncated to 127 characters
// - Select reads start and length bytes
// - Bit 7 set selects register low byte
// - Clamp start and length to string end
// - Load replaces buffer, point at end
// - Convert selection to float or long
// - Result to reg 0 or reg 128
// - Swap exchanges two numbered registers
// - Mixed swap moves low half, zeroes upper
// - Swap with accumulator, same width rules
// - Sync returns 0x5C to host
// - Table only in flash; size zero means 256
// - Table loads indexed entry; out of range zero
// - Entry count mismatch ignores table command
// - Wide destination gets low half, upper cleared
// - Tangent: NaN/inf give NaN, zeros kept
// - Fine tick: ms to reg 0, us to 128
// - Read seconds to reg 0 or 128, status
// - Load seconds; minus one stops timer
// - Trace off ignored unless debugger enabled
module stce_exec (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_byte,
  input  wire logic        i_cmd_last,
  input  wire logic        i_in_flash,
  input  wire logic        i_debug_enable,
  input  wire logic [7:0]  i_acc_index,
  input  wire logic [63:0] i_reg_rdata,
  input  wire logic [63:0] i_conv_result,
  input  wire logic [63:0] i_tan_result,
  output logic             o_cmd_ready,
  output logic [7:0]       o_reg_addr,
  output logic             o_reg_we,
  output logic [63:0]      o_reg_wdata,
  output logic             o_reply_valid,
  output logic [7:0]       o_reply_byte,
  output logic             o_log_valid,
  output logic [7:0]       o_log_byte,
  output logic             o_conv_start,
  output logic             o_conv_real,
  output logic             o_tan_start,
  output logic [7:0]       o_status,
  output logic [6:0]       o_sel_start,
  output logic [6:0]       o_sel_length,
  output logic [6:0]       o_text_length,
  output logic             o_timer_on
);
  import stce_pkg::*;

  typedef struct packed {
    stce_state_t st;
    logic [7:0]  op;
    logic [7:0]  arg1;
    logic [7:0]  arg2;
    logic [8:0]  tbl_size;
    logic [10:0] tbl_cnt;
    logic [31:0] tbl_word;
    logic [31:0] tbl_hit;
    logic [31:0] tbl_index;
    logic [1:0]  step;
    logic [63:0] val_a;
    logic [6:0]  txt_len;
    logic [6:0]  sel_pt;
    logic [6:0]  sel_len;
    logic [6:0]  ins_pt;
    logic [6:0]  str_cnt;
    logic        tracing;
    logic        timer_on;
    logic [31:0] seconds;
    logic [31:0] msec;
    logic [63:0] usec;
    logic [9:0]  ms_div;
    logic [9:0]  s_div;
    logic [6:0]  cyc_div;
    logic [7:0]  status;
    logic        ready;
    logic [7:0]  reg_addr;
    logic        reg_we;
    logic [63:0] reg_wdata;
    logic        reply_v;
    logic [7:0]  reply_b;
    logic        log_v;
    logic        conv_start;
    logic        conv_real;
    logic        tan_start;
  } stce_reg_t;

  stce_reg_t  s_reg;
  stce_reg_t  s_next;
  logic [7:0] text_mem [0:127];
  logic       mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_data;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] clamp7(input logic [7:0] v, input logic [6:0] lim);
    clamp7 = (v > {1'b0, lim}) ? lim : v[6:0];
  endfunction

  // Narrow view of a value, upper half cleared
  function automatic logic [63:0] lo32(input logic [63:0] v);
    lo32 = {32'h0000_0000, v[31:0]};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       take;
    logic [7:0] res_reg;
    logic [7:0] st8;
    logic [7:0] ln8;
    logic [7:0] sum8;
    s_next = s_reg;
    take = i_cmd_valid && s_reg.ready;
    res_reg = i_acc_index[7] ? REG_WIDE_BASE : REG_ZERO;
    st8 = 8'h00;
    ln8 = 8'h00;
    sum8 = 8'h00;
    mem_we = 1'b0;
    mem_addr = s_reg.ins_pt;
    mem_data = i_cmd_byte;
    s_next.reg_we = 1'b0;
    s_next.reply_v = 1'b0;
    s_next.log_v = 1'b0;
    s_next.conv_start = 1'b0;
    s_next.tan_start = 1'b0;
    // Free-running microsecond prescaler; counters advance only while the timer is on
    s_next.cyc_div = (s_reg.cyc_div == 7'(CYC_PER_US - 1)) ? 7'h00 : s_reg.cyc_div + 7'h01;
    if (s_reg.timer_on && s_reg.cyc_div == 7'(CYC_PER_US - 1)) begin
      s_next.usec = s_reg.usec + 64'h0000_0000_0000_0001;
      s_next.ms_div = (s_reg.ms_div == US_PER_MS - 10'h001) ? 10'h000 : s_reg.ms_div + 10'h001;
      if (s_reg.ms_div == US_PER_MS - 10'h001) begin
        s_next.msec = s_reg.msec + 32'h0000_0001;
        s_next.s_div = (s_reg.s_div == MS_PER_S - 10'h001) ? 10'h000 : s_reg.s_div + 10'h001;
        if (s_reg.s_div == MS_PER_S - 10'h001) begin
          s_next.seconds = s_reg.seconds + 32'h0000_0001;
        end
      end
    end
    case (s_reg.st)
      ST_OPCODE: begin
        if (take) begin
          s_next.op = i_cmd_byte;
          s_next.step = 2'd0;
          s_next.str_cnt = 7'h00;
          case (i_cmd_byte)
            OP_SEL_DEFINE, OP_SWAP, OP_SWAP_ACC: s_next.st = ST_ARG1;
            OP_TEXT_LOAD: begin
              s_next.txt_len = 7'h00;
              s_next.ins_pt = 7'h00;
              s_next.st = ST_STRING;
            end
            OP_TEXT_INSERT: begin
              s_next.ins_pt = s_reg.sel_pt;
              s_next.st = ST_STRING;
            end
            OP_TABLE: begin
              s_next.reg_addr = res_reg;
              s_next.st = i_in_flash ? ST_TBL_SIZE : ST_EXEC;
            end
            default: s_next.st = ST_EXEC;
          endcase
          s_next.ready = (s_next.st != ST_EXEC);
        end
      end
      ST_ARG1: begin
        if (take) begin
          s_next.arg1 = i_cmd_byte;
          s_next.st = (s_reg.op == OP_SWAP_ACC) ? ST_REG_RD : ST_ARG2;
          s_next.ready = (s_reg.op != OP_SWAP_ACC);
          if (s_reg.op == OP_SWAP_ACC) begin
            s_next.arg2 = i_acc_index;
          end
        end
      end
      ST_ARG2: begin
        if (take) begin
          s_next.arg2 = i_cmd_byte;
          s_next.ready = 1'b0;
          s_next.st = ST_REG_RD;
        end
      end
      ST_STRING: begin
        if (take) begin
          if (i_cmd_byte == 8'h00) begin
            s_next.sel_pt = s_reg.ins_pt;
            s_next.sel_len = 7'h00;
            s_next.st = ST_OPCODE;
          end else if (s_reg.str_cnt != TEXT_MAX && s_reg.txt_len != TEXT_MAX) begin
            // Insert overwrites in place; shifting the tail would need a second pass
            mem_we = 1'b1;
            s_next.ins_pt = s_reg.ins_pt + 7'h01;
            s_next.str_cnt = s_reg.str_cnt + 7'h01;
            if (s_reg.ins_pt >= s_reg.txt_len) begin
              s_next.txt_len = s_reg.txt_len + 7'h01;
            end
          end
        end
      end
      ST_TBL_SIZE: begin
        if (take) begin
          s_next.tbl_size = (i_cmd_byte == 8'h00) ? 9'h100 : {1'b0, i_cmd_byte};
          s_next.tbl_cnt = 11'h000;
          s_next.tbl_hit = 32'h0000_0000;
          s_next.tbl_index = i_reg_rdata[31:0];
          s_next.st = ST_TBL_DATA;
        end
      end
      ST_TBL_DATA: begin
        if (take) begin
          s_next.tbl_word = {s_reg.tbl_word[23:0], i_cmd_byte};
          s_next.tbl_cnt = s_reg.tbl_cnt + 11'h001;
          if (s_reg.tbl_cnt[1:0] == 2'd3 &&
              {23'h00_0000, s_reg.tbl_cnt[10:2]} == s_reg.tbl_index) begin
            s_next.tbl_hit = {s_reg.tbl_word[23:0], i_cmd_byte};
          end
          if (i_cmd_last) begin
            if (s_reg.tbl_cnt + 11'h001 == {s_reg.tbl_size, 2'b00}) begin
              s_next.reg_we = 1'b1;
              s_next.reg_addr = res_reg;
              s_next.reg_wdata = {32'h0000_0000, s_next.tbl_hit};
            end
            s_next.st = ST_OPCODE;
            s_next.ready = 1'b1;
          end
        end
      end
      ST_REG_RD: begin
        // Read data belongs to the address standing in this cycle
        s_next.step = s_reg.step + 2'd1;
        if (s_reg.step == 2'd0) begin
          s_next.reg_addr = (s_reg.op == OP_SEL_DEFINE) ? {1'b0, s_reg.arg1[6:0]} : s_reg.arg1;
        end else if (s_reg.step == 2'd1) begin
          s_next.val_a = i_reg_rdata;
          s_next.reg_addr = (s_reg.op == OP_SEL_DEFINE) ? {1'b0, s_reg.arg2[6:0]} : s_reg.arg2;
        end else if (s_reg.step == 2'd3) begin
          s_next.step = 2'd0;
          s_next.st = ST_REG_WR;
          if (s_reg.op == OP_SEL_DEFINE) begin
            st8 = s_reg.arg1[7] ? s_reg.val_a[7:0] : {1'b0, s_reg.arg1[6:0]};
            ln8 = s_reg.arg2[7] ? i_reg_rdata[7:0] : {1'b0, s_reg.arg2[6:0]};
            st8 = {1'b0, clamp7(st8, s_reg.txt_len)};
            sum8 = st8 + ln8;
            s_next.sel_pt = st8[6:0];
            s_next.sel_len = (sum8 > {1'b0, s_reg.txt_len} || sum8 < st8) ?
                             s_reg.txt_len - st8[6:0] : ln8[6:0];
            s_next.st = ST_OPCODE;
            s_next.ready = 1'b1;
          end else begin
            s_next.reg_we = 1'b1;
            s_next.reg_addr = s_reg.arg1;
            s_next.reg_wdata = (s_reg.arg1[7] != s_reg.arg2[7]) ? lo32(i_reg_rdata) : i_reg_rdata;
          end
        end
      end
      ST_REG_WR: begin
        s_next.reg_we = 1'b1;
        s_next.reg_addr = s_reg.arg2;
        s_next.reg_wdata = (s_reg.arg1[7] != s_reg.arg2[7]) ? lo32(s_reg.val_a) : s_reg.val_a;
        s_next.st = ST_OPCODE;
        s_next.ready = 1'b1;
      end
      ST_EXEC: begin
        s_next.st = ST_OPCODE;
        s_next.ready = 1'b1;
        case (s_reg.op)
          OP_SEL_ADVANCE: begin
            if (s_reg.sel_pt < s_reg.txt_len) begin
              s_next.sel_pt = s_reg.sel_pt + 7'h01;
            end
            s_next.sel_len = 7'h00;
          end
          OP_TO_REAL, OP_TO_INTEGER: begin
            // Converter result is consumed by the next step
            s_next.conv_start = (s_reg.step == 2'd0);
            s_next.conv_real = (s_reg.op == OP_TO_REAL);
            if (s_reg.step == 2'd0) begin
              s_next.step = 2'd1;
              s_next.st = ST_EXEC;
              s_next.ready = 1'b0;
            end else begin
              s_next.reg_we = 1'b1;
              s_next.reg_addr = res_reg;
              s_next.reg_wdata = res_reg[7] ? i_conv_result : lo32(i_conv_result);
            end
          end
          OP_TANGENT: begin
            // Special cases are the numeric unit's job: NaN, inf and signed zero pass through
            s_next.tan_start = (s_reg.step == 2'd0);
            if (s_reg.step == 2'd0) begin
              s_next.step = 2'd1;
              s_next.st = ST_EXEC;
              s_next.ready = 1'b0;
            end else begin
              s_next.reg_we = 1'b1;
              s_next.reg_addr = i_acc_index;
              s_next.reg_wdata = i_acc_index[7] ? i_tan_result : lo32(i_tan_result);
            end
          end
          OP_SYNC: begin
            s_next.reply_v = 1'b1;
            s_next.reply_b = SYNC_REPLY;
          end
          OP_FINE_TICK, OP_READ_SEC: begin
            s_next.reg_we = 1'b1;
            s_next.reg_addr = res_reg;
            if (s_reg.op == OP_READ_SEC) begin
              s_next.reg_wdata = {32'h0000_0000, s_reg.seconds};
            end else begin
              s_next.reg_wdata = res_reg[7] ? lo32(s_reg.usec) : {32'h0000_0000, s_reg.msec};
            end
            s_next.status = {s_next.reg_wdata[31], 6'h00, s_next.reg_wdata[31:0] == 32'h0000_0000};
          end
          OP_LOAD_SEC: begin
            if (s_reg.step == 2'd0) begin
              s_next.reg_addr = res_reg;
              s_next.step = 2'd1;
              s_next.st = ST_EXEC;
              s_next.ready = 1'b0;
            end else if (s_reg.step == 2'd1) begin
              s_next.step = 2'd2;
              s_next.st = ST_EXEC;
              s_next.ready = 1'b0;
            end else if (i_reg_rdata == (res_reg[7] ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF)) begin
              s_next.timer_on = 1'b0;
            end else begin
              s_next.timer_on = 1'b1;
              s_next.seconds = i_reg_rdata[31:0];
              s_next.msec = i_reg_rdata[31:0] * 32'd1000;
              s_next.usec = 64'(i_reg_rdata[31:0]) * 64'd1000000;
              s_next.ms_div = 10'h000;
              s_next.s_div = 10'h000;
            end
          end
          OP_LOG_STOP: begin
            if (i_debug_enable) begin
              s_next.tracing = 1'b0;
              s_next.log_v = 1'b1;
            end
          end
          default: ;
        endcase
      end
      default: s_next.st = ST_OPCODE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s_reg <= '0;
      s_reg.st <= ST_OPCODE;
      s_reg.ready <= 1'b1;
      s_reg.tracing <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (mem_we) begin
      text_mem[mem_addr] <= mem_data;
    end
  end

  assign o_cmd_ready   = s_reg.ready;
  assign o_reg_addr    = s_reg.reg_addr;
  assign o_reg_we      = s_reg.reg_we;
  assign o_reg_wdata   = s_reg.reg_wdata;
  assign o_reply_valid = s_reg.reply_v;
  assign o_reply_byte  = s_reg.reply_b;
  assign o_log_valid   = s_reg.log_v;
  assign o_log_byte    = LOG_STOP_CHAR;
  assign o_conv_start  = s_reg.conv_start;
  assign o_conv_real   = s_reg.conv_real;
  assign o_tan_start   = s_reg.tan_start;
  assign o_status      = s_reg.status;
  assign o_sel_start   = s_reg.sel_pt;
  assign o_sel_length  = s_reg.sel_len;
  assign o_text_length = s_reg.txt_len;
  assign o_timer_on    = s_reg.timer_on;
endmodule

//--- testbench/stce_exec_properties.sv
// Port-level assertions for the string/timer command executer
`timescale 1ns/1ps
module stce_exec_checker
  import stce_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic       i_debug_enable,
  input wire logic [7:0] i_acc_index,
  input wire logic       o_cmd_ready,
  input wire logic [7:0] o_reg_addr,
  input wire logic       o_reg_we,
  input wire logic       o_reply_valid,
  input wire logic [7:0] o_reply_byte,
  input wire logic       o_log_valid,
  input wire logic [7:0] o_log_byte,
  input wire logic       o_conv_start,
  input wire logic       o_tan_start,
  input wire logic [6:0] o_sel_start,
  input wire logic [6:0] o_sel_length,
  input wire logic [6:0] o_text_length,
  input wire logic       o_timer_on
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // Multi-step behaviours
  // ----------------------------------------
  sequence s_conv_store;
    ##[1:4] (o_reg_we && o_reg_addr == (i_acc_index[7] ? REG_WIDE_BASE : REG_ZERO));
  endsequence
  sequence s_tan_store;
    ##[1:4] (o_reg_we && o_reg_addr == i_acc_index);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_reset_state: assert property ($past(i_reset) |-> o_cmd_ready && !o_timer_on && o_text_length == 7'h00)
    else $error("state after reset wrong");
  chk_sync_cause: assert property (o_reply_valid |-> $past(i_cmd_valid && o_cmd_ready && i_cmd_byte == OP_SYNC, 2))
    else $error("reply without sync opcode");
  chk_sync_value: assert property (o_reply_valid |-> o_reply_byte == SYNC_REPLY && o_cmd_ready)
    else $error("sync reply byte wrong");
  chk_log_gate: assert property (o_log_valid |-> i_debug_enable && o_log_byte == LOG_STOP_CHAR)
    else $error("trace-off message while debugger off");
  // Judged at completion only
  chk_sel_bounds: assert property ($rose(o_cmd_ready) |->
      ({1'b0, o_sel_start} + {1'b0, o_sel_length}) <= {1'b0, o_text_length})
    else $error("selection past string end");
  chk_busy_bound: assert property ($fell(o_cmd_ready) |-> ##[1:300] o_cmd_ready)
    else $error("command never completes");
  chk_conv_store: assert property (o_conv_start |-> s_conv_store)
    else $error("conversion result not stored");
  chk_tan_store: assert property (o_tan_start |-> s_tan_store)
    else $error("tangent not stored to accumulator");
  chk_conv_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start longer than a cycle");
endmodule

bind stce_exec stce_exec_checker i_stce_exec_checker (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
  .i_debug_enable(i_debug_enable), .i_acc_index(i_acc_index), .o_cmd_ready(o_cmd_ready),
  .o_reg_addr(o_reg_addr), .o_reg_we(o_reg_we), .o_reply_valid(o_reply_valid), .o_reply_byte(o_reply_byte),
  .o_log_valid(o_log_valid), .o_log_byte(o_log_byte), .o_conv_start(o_conv_start), .o_tan_start(o_tan_start),
  .o_sel_start(o_sel_start), .o_sel_length(o_sel_length), .o_text_length(o_text_length),
  .o_timer_on(o_timer_on));

//--- testbench/stce_regfile_model.sv
// Register file model behind the executer's register port
`timescale 1ns/1ps
module stce_regfile_model (
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_we,
  input  wire logic [63:0] i_wdata,
  output logic      [63:0] o_rdata
);
  logic [63:0] mem [256];
  // Registers below 128 are 32 bits wide: writes and put clear the upper half
  assign o_rdata = mem[i_addr];
  always @(posedge i_core_clk) if (i_we) mem[i_addr] <= i_addr[7] ? i_wdata : {32'h0000_0000, i_wdata[31:0]};
  task automatic put(input logic [7:0] a, input logic [63:0] v);
    mem[a] = a[7] ? v : {32'h0000_0000, v[31:0]};
  endtask
  initial foreach (mem[k]) mem[k] = {8{k[7:0]}};
endmodule

//--- testbench/stce_exec_tb.sv
// Self-checking bench for the string/timer command executer
`timescale 1ns/1ps
module stce_exec_tb;
  import stce_pkg::*;
  logic        i_core_clk, i_reset, i_cmd_valid, i_cmd_last, i_in_flash, i_debug_enable, conv_kind;
  logic [7:0]  i_cmd_byte, i_acc_index, o_reg_addr, o_reply_byte, o_log_byte, o_status, last_reply, last_log;
  logic [63:0] i_reg_rdata, o_reg_wdata;
  logic [63:0] i_conv_result = 64'h4049_0FDB_1122_3344;
  logic [63:0] i_tan_result  = 64'hBFF0_0000_5566_7788;
  logic        o_cmd_ready, o_reg_we, o_reply_valid, o_log_valid, o_conv_start, o_conv_real, o_tan_start, o_timer_on;
  logic [6:0]  o_sel_start, o_sel_length, o_text_length;
  int          err_count, check_count, replies, logs;

  stce_exec i_stce_exec (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
    .i_cmd_last(i_cmd_last), .i_in_flash(i_in_flash), .i_debug_enable(i_debug_enable),
    .i_acc_index(i_acc_index), .i_reg_rdata(i_reg_rdata), .i_conv_result(i_conv_result),
    .i_tan_result(i_tan_result), .o_cmd_ready(o_cmd_ready), .o_reg_addr(o_reg_addr), .o_reg_we(o_reg_we),
    .o_reg_wdata(o_reg_wdata), .o_reply_valid(o_reply_valid), .o_reply_byte(o_reply_byte),
    .o_log_valid(o_log_valid), .o_log_byte(o_log_byte), .o_conv_start(o_conv_start), .o_conv_real(o_conv_real),
    .o_tan_start(o_tan_start), .o_status(o_status), .o_sel_start(o_sel_start), .o_sel_length(o_sel_length),
    .o_text_length(o_text_length), .o_timer_on(o_timer_on));
  stce_regfile_model i_stce_regfile_model (
    .i_core_clk(i_core_clk), .i_addr(o_reg_addr), .i_we(o_reg_we), .i_wdata(o_reg_wdata), .o_rdata(i_reg_rdata));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ----------------------------------------
  // Pulse monitors
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (o_reply_valid === 1'b1) begin replies++; last_reply = o_reply_byte; end
    if (o_log_valid === 1'b1) begin logs++; last_log = o_log_byte; end
    if (o_conv_start === 1'b1) conv_kind = o_conv_real;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Request held until ready is seen high at an edge
  task automatic send(input logic [7:0] b, input logic last = 1'b0);
    int n;
    n = 0;
    i_cmd_valid <= 1'b1;
    i_cmd_byte  <= b;
    i_cmd_last  <= last;
    @(posedge i_core_clk);
    while (o_cmd_ready !== 1'b1 && n < 300) begin @(posedge i_core_clk); n++; end
    if (n == 300) check(0, 1, "byte never taken");
  endtask
  // A taken NOP marks completion
  task automatic done();
    send(8'h00);
    i_cmd_valid <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask
  task automatic str(input string s);
    foreach (s[k]) send(s[k]);
    send(8'h00);
  endtask
  task automatic cmd(input logic [7:0] op, input int n = 0, input logic [7:0] a = 0, input logic [7:0] b = 0);
    send(op);
    if (n > 0) send(a);
    if (n > 1) send(b);
    done();
  endtask
  task automatic sel_is(input int s, input int l);
    check(o_sel_start, s, "selection start");
    check(o_sel_length, l, "selection length");
  endtask
  function automatic logic [63:0] rd(input int a);
    return i_stce_regfile_model.mem[a];
  endfunction
  task automatic pr(input logic [7:0] a, input logic [63:0] v);
    i_stce_regfile_model.put(a, v);
  endtask
  task automatic table_cmd(input logic [7:0] size, input int n);
    send(OP_TABLE);
    send(size);
    for (int k = 0; k < n; k++)
      for (int j = 0; j < 4; j++) send(j == 0 ? 8'hA0 + k[7:0] : 8'h11 * j[7:0], k == n - 1 && j == 3);
    done();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_sync();
    replies = 0;
    cmd(OP_SYNC);
    check(replies, 1, "sync count");
    check(last_reply, SYNC_REPLY, "sync reply byte");
    $display("test sync done");
  endtask
  task automatic t_text();
    send(OP_TEXT_LOAD);
    str("ABC");
    done();
    check(o_text_length, 3, "load length");
    sel_is(3, 0);
    send(OP_TEXT_INSERT);
    str("XY");
    done();
    check(o_text_length, 5, "insert length");
    sel_is(5, 0);
    cmd(OP_SEL_DEFINE, 2, 8'h01, 8'h02);
    sel_is(1, 2);
    cmd(OP_SEL_ADVANCE);
    sel_is(2, 0);
    cmd(OP_SEL_DEFINE, 2, 8'h03, 8'h09);
    sel_is(3, 2);
    cmd(OP_SEL_DEFINE, 2, 8'h20, 8'h00);
    sel_is(5, 0);
    cmd(OP_SEL_ADVANCE);
    sel_is(5, 0);
    pr(8'h05, 64'h0000_0000_7700_0201);
    pr(8'h06, 64'h0000_0000_0000_0302);
    cmd(OP_SEL_DEFINE, 2, 8'h85, 8'h86);
    sel_is(1, 2);
    send(OP_TEXT_LOAD);
    repeat (130) send(8'h41);
    send(8'h00);
    done();
    check(o_text_length, 127, "truncated length");
    $display("test text done");
  endtask
  task automatic t_regs();
    pr(8'h03, 64'h0000_0000_1111_2222);
    pr(8'h82, 64'hAAAA_BBBB_CCCC_DDDD);
    cmd(OP_SWAP, 2, 8'h03, 8'h82);
    check(rd(3), 64'h0000_0000_CCCC_DDDD, "mixed swap narrow");
    check(rd(130), 64'h0000_0000_1111_2222, "mixed swap wide");
    pr(8'h81, 64'h1234_5678_9ABC_DEF0);
    pr(8'h83, 64'h0FED_CBA9_8765_4321);
    cmd(OP_SWAP, 2, 8'h81, 8'h83);
    check(rd(129), 64'h0FED_CBA9_8765_4321, "wide swap a");
    check(rd(131), 64'h1234_5678_9ABC_DEF0, "wide swap b");
    i_acc_index <= 8'h84;
    pr(8'h84, 64'h5555_6666_7777_8888);
    pr(8'h07, 64'h0000_0000_9999_AAAA);
    cmd(OP_SWAP_ACC, 1, 8'h07);
    check(rd(132), 64'h0000_0000_9999_AAAA, "acc swap acc");
    check(rd(7), 64'h0000_0000_7777_8888, "acc swap reg");
    i_acc_index <= 8'h02;
    cmd(OP_TO_REAL);
    check(rd(0), 64'h0000_0000_1122_3344, "real to reg 0");
    check(conv_kind, 1, "real kind");
    i_acc_index <= 8'h90;
    cmd(OP_TO_INTEGER);
    check(rd(128), i_conv_result, "integer to reg 128");
    check(conv_kind, 0, "integer kind");
    i_acc_index <= 8'h88;
    cmd(OP_TANGENT);
    check(rd(136), i_tan_result, "tangent store");
    $display("test registers done");
  endtask
  task automatic t_timer();
    i_acc_index <= 8'h01;
    pr(8'h00, 64'h0000_0000_0000_0005);
    cmd(OP_LOAD_SEC);
    check(o_timer_on, 1, "timer enabled");
    pr(8'h00, 64'h0000_0000_0000_0009);
    cmd(OP_READ_SEC);
    check(rd(0), 64'h0000_0000_0000_0005, "seconds read");
    check(o_status[0], 0, "nonzero status");
    cmd(OP_FINE_TICK);
    check(rd(0) < 64'd5001, 1, "millisecond ticks");
    i_acc_index <= 8'h80;
    pr(8'h80, 64'h0000_0000_0000_0000);
    cmd(OP_LOAD_SEC);
    pr(8'h80, 64'hFFFF_0000_0000_0009);
    cmd(OP_READ_SEC);
    check(rd(128), 0, "wide seconds read");
    check(o_status[0], 1, "zero status");
    cmd(OP_FINE_TICK);
    check(rd(128) < 64'd100, 1, "microsecond ticks");
    i_acc_index <= 8'h01;
    pr(8'h00, 64'h0000_0000_FFFF_FFFF);
    cmd(OP_LOAD_SEC);
    check(o_timer_on, 0, "timer disabled");
    $display("test timer done");
  endtask
  task automatic t_table();
    i_in_flash  <= 1'b1;
    i_acc_index <= 8'h80;
    pr(8'h80, 64'hFFFF_FFFF_0000_0001);
    table_cmd(8'h02, 2);
    check(rd(128), 64'h0000_0000_A111_2233, "table entry one");
    pr(8'h80, 64'h0000_0000_0000_0005);
    table_cmd(8'h02, 2);
    check(rd(128), 0, "index past table");
    pr(8'h80, 64'h0000_0000_0000_0001);
    table_cmd(8'h03, 2);
    check(rd(128), 64'h0000_0000_0000_0001, "count mismatch ignored");
    pr(8'h80, 64'h0000_0000_0000_00FF);
    table_cmd(8'h00, 256);
    check(rd(128), 64'h0000_0000_9F11_2233, "size zero means 256");
    i_in_flash <= 1'b0;
    pr(8'h80, 64'h0000_0000_0000_0001);
    cmd(OP_TABLE);
    check(rd(128), 64'h0000_0000_0000_0001, "table outside flash");
    $display("test table done");
  endtask
  task automatic t_log();
    logs = 0;
    cmd(OP_LOG_STOP);
    check(logs, 0, "log while off");
    i_debug_enable <= 1'b1;
    cmd(OP_LOG_STOP);
    check(logs, 1, "log count");
    check(last_log, LOG_STOP_CHAR, "log byte");
    $display("test trace done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {i_reset, i_cmd_valid, i_cmd_byte, i_cmd_last, i_in_flash, i_debug_enable, i_acc_index} = {1'b1, 20'h0_0000};
    repeat (10) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    t_sync();
    t_text();
    t_regs();
    t_timer();
    t_table();
    t_sync();
    t_log();
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge i_core_clk);
    err_count++;
    report_and_stop();
  end
endmodule
